// ===== hdl/tcm_ctrl.sv
// connection memories, data-memory pages, block programming, host port, tristate control
`timescale 1ns/10ps
module tcm_ctrl #(
  parameter int DEPTH = tcm_pkg::CM_DEPTH,
  parameter int PAGE_COUNT = tcm_pkg::PAGES,
  parameter int DIV = tcm_pkg::BIT_DIV
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // host port pins
  input wire logic i_cs_n,
  input wire logic i_ds_n,
  input wire logic i_rw,
  input wire logic [14:0] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe,
  output logic o_read_invalid,
  output logic o_transfer_ack_n,
  input wire logic i_master_clock_ok,
  // control bits
  input wire logic [2:0] i_mem_select,
  input wire logic i_block_prog_mode_bit,
  input wire logic i_block_prog_enable_set,
  input wire logic i_block_prog_enable_clear,
  input wire logic [2:0] i_local_block_data,
  input wire logic [2:0] i_bp_block_data,
  output logic o_block_prog_enable_bit,
  // backplane output control
  input wire logic i_bp_out_reset_state_pin,
  input wire logic [31:0] i_bp_stream_rate,
  output logic [1:0] o_bp_tristate_ctrl_out,
  output logic [1:0] o_bp_tristate_ctrl_oe,
  output logic [15:0] o_bp_serial_oe,
  // switching datapath
  input wire tcm_pkg::tcm_dm_wr_s i_dm_wr,
  input wire tcm_pkg::tcm_sw_req_s i_sw_req,
  output logic [7:0] o_sw_data,
  output logic o_sw_valid,
  output logic [1:0] o_frame_page
);
  tcm_pkg::tcm_host_pins_s pins_sync;
  logic [2:0] misc_sync;

  // pins cross from the host's timing domain
  tcm_sync #(.WIDTH(34), .RESET_VAL(34'h3_0000_0000)) u_host_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_ds_n, i_rw, i_addr, i_data}),
    .o_sync(pins_sync)
  );
  tcm_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_misc_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({i_master_clock_ok, i_bp_out_reset_state_pin, 1'b0}),
    .o_sync(misc_sync)
  );
  logic clk_ok;
  logic bp_out_reset_state_pin;
  assign clk_ok = misc_sync[2];
  assign bp_out_reset_state_pin = misc_sync[1];

  // storage
  // two connection memories
  logic [15:0] local_conn_mem [DEPTH];
  logic [15:0] bp_conn_mem [DEPTH];
  logic [7:0] local_dm [PAGE_COUNT][DEPTH];
  logic [7:0] bp_dm [PAGE_COUNT][DEPTH];

  // frame timing
  logic [$clog2(DIV)-1:0] div_reg, div_next;
  logic [10:0] count_reg, count_next;
  logic [1:0] page_reg, page_next;
  logic tick;
  assign tick = (div_reg == ($clog2(DIV))'(DIV - 1));

  always_comb begin
    div_next = tick ? '0 : div_reg + 1'b1;
    count_next = tick ? count_reg + 11'h001 : count_reg;
    page_next = page_reg;
    if (tick && count_reg == tcm_pkg::LAST_COUNT) begin
      page_next = page_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= '0;
      count_reg <= 11'h000;
      page_reg <= 2'h0;
    end else begin
      div_reg <= div_next;
      count_reg <= count_next;
      page_reg <= page_next;
    end
  end

  // channel index for a stream at a given slot
  function automatic logic [7:0] rate_chan(input logic [1:0] rate, input logic [7:0] slot);
    case (tcm_pkg::tcm_rate_e'(rate))
      tcm_pkg::RATE_16M: rate_chan = slot;
      tcm_pkg::RATE_8M: rate_chan = {1'b0, slot[7:1]};
      tcm_pkg::RATE_4M: rate_chan = {2'h0, slot[7:2]};
      default: rate_chan = {3'h0, slot[7:3]};
    endcase
  endfunction : rate_chan

  // tristate control serial outputs
  logic [10:0] ctrl_off;
  logic [3:0] even_st, odd_st;
  logic [7:0] even_ch, odd_ch;
  logic [1:0] ctrl_reg, ctrl_next, ctrl_oe_reg, ctrl_oe_next;
  logic [15:0] soe_reg, soe_next;
  logic [7:0] out_slot;

  always_comb begin
    // offset from period 2039; period number is count plus one
    ctrl_off = count_reg + 11'h001 - tcm_pkg::CTRL_START_PERIOD;
    even_st = {ctrl_off[2:0], 1'b0};
    odd_st = {ctrl_off[2:0], 1'b1};
    even_ch = rate_chan(i_bp_stream_rate[2*even_st +: 2], ctrl_off[10:3]);
    odd_ch = rate_chan(i_bp_stream_rate[2*odd_st +: 2], ctrl_off[10:3]);
    out_slot = count_reg[10:3];
    ctrl_next = ctrl_reg;
    // one bit each period, repeats come from the rate scaling
    if (tick) begin
      ctrl_next[0] = bp_conn_mem[{even_st, even_ch}][tcm_pkg::OUT_EN_BIT];
      ctrl_next[1] = bp_conn_mem[{odd_st, odd_ch}][tcm_pkg::OUT_EN_BIT];
    end
    ctrl_oe_next = bp_out_reset_state_pin ? 2'h0 : 2'h3;
    for (int s = 0; s < tcm_pkg::NUM_STREAMS; s++) begin
      // with the reset-state pin high, a low enable bit floats the stream for its channel
      soe_next[s] = !bp_out_reset_state_pin ||
        bp_conn_mem[{4'(s), rate_chan(i_bp_stream_rate[2*s +: 2], out_slot)}][tcm_pkg::OUT_EN_BIT];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= 2'h0;
      ctrl_oe_reg <= 2'h0;
      soe_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      ctrl_oe_reg <= ctrl_oe_next;
      soe_reg <= soe_next;
    end
  end

  // switching read path
  logic [7:0] sw_data_reg, sw_data_next;
  logic sw_valid_reg, sw_valid_next;
  logic [15:0] sw_word;
  logic [1:0] rd_page;

  always_comb begin
    // read page lags write page by three frames
    rd_page = page_reg + 2'h1;
    sw_word = i_sw_req.bp_port ? bp_conn_mem[{i_sw_req.stream, i_sw_req.channel}]
                               : local_conn_mem[{i_sw_req.stream, i_sw_req.channel}];
    sw_valid_next = i_sw_req.valid;
    sw_data_next = sw_data_reg;
    if (i_sw_req.valid) begin
      if (sw_word[tcm_pkg::MSG_MODE_BIT]) begin
        sw_data_next = sw_word[7:0];
      // bit 15 low takes the opposite port
      end else if (sw_word[tcm_pkg::SRC_PORT_BIT] == i_sw_req.bp_port) begin
        // stream and channel from bits 11:0
        sw_data_next = bp_dm[rd_page][{sw_word[11:8], sw_word[7:0]}];
      end else begin
        sw_data_next = local_dm[rd_page][{sw_word[11:8], sw_word[7:0]}];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sw_data_reg <= 8'h00;
      sw_valid_reg <= 1'b0;
    end else begin
      sw_data_reg <= sw_data_next;
      sw_valid_reg <= sw_valid_next;
    end
  end

  // block programming
  logic bpe_reg, bpe_next;
  logic [11:0] bp_idx_reg, bp_idx_next;
  logic [2:0] lbd_reg, lbd_next, bbd_reg, bbd_next;
  logic bp_write;

  always_comb begin
    bpe_next = bpe_reg;
    bp_idx_next = bp_idx_reg;
    lbd_next = lbd_reg;
    bbd_next = bbd_reg;
    bp_write = 1'b0;
    // enable only takes when mode bit already high
    if (!bpe_reg && i_block_prog_enable_set && i_block_prog_mode_bit) begin
      bpe_next = 1'b1;
      bp_idx_next = 12'h000;
      lbd_next = i_local_block_data;
      bbd_next = i_bp_block_data;
    end else if (bpe_reg && (i_block_prog_enable_clear || !i_block_prog_mode_bit)) begin
      bpe_next = 1'b0;
    end else if (bpe_reg) begin
      bp_write = 1'b1;
      bp_idx_next = bp_idx_reg + 12'h001;
      // 4096 cycles, well inside the limit
      if (bp_idx_reg == 12'(DEPTH - 1)) begin
        bpe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bpe_reg <= 1'b0;
      bp_idx_reg <= 12'h000;
      lbd_reg <= tcm_pkg::BLOCK_DATA_RESET;
      bbd_reg <= tcm_pkg::BLOCK_DATA_RESET;
    end else begin
      bpe_reg <= bpe_next;
      bp_idx_reg <= bp_idx_next;
      lbd_reg <= lbd_next;
      bbd_reg <= bbd_next;
    end
  end

  // host port
  tcm_pkg::tcm_host_state_e hs_reg, hs_next;
  logic [15:0] rdata_reg, rdata_next;
  logic oe_reg, oe_next, inv_reg, inv_next, ack_n_reg, ack_n_next;
  logic host_cm_wr, host_sel;
  logic [11:0] host_idx;

  always_comb begin
    hs_next = hs_reg;
    rdata_next = rdata_reg;
    oe_next = oe_reg;
    inv_next = inv_reg;
    ack_n_next = ack_n_reg;
    host_cm_wr = 1'b0;
    // low twelve address bits index the memory
    host_idx = pins_sync.addr[11:0];
    // select and strobe both low start a cycle
    host_sel = !pins_sync.cs_n && !pins_sync.ds_n;
    case (hs_reg)
      tcm_pkg::HS_IDLE: begin
        if (host_sel) begin
          hs_next = tcm_pkg::HS_ACK;
          ack_n_next = 1'b0;
          oe_next = pins_sync.rw;
          // handshake always completes, data flagged without clock
          inv_next = !clk_ok;
          rdata_next = 16'h0000;
          // top address bit selects memory space
          if (!clk_ok) begin
            rdata_next = tcm_pkg::INVALID_DATA;
          end else if (pins_sync.addr[tcm_pkg::MEM_SPACE_BIT]) begin
            // connection memories writable, data memories read only
            if (i_mem_select == tcm_pkg::SEL_LOCAL_CM || i_mem_select == tcm_pkg::SEL_BP_CM) begin
              host_cm_wr = !pins_sync.rw && !bpe_reg;
            end
            if (i_mem_select == tcm_pkg::SEL_LOCAL_CM) begin
              rdata_next = local_conn_mem[host_idx];
            end else if (i_mem_select == tcm_pkg::SEL_BP_CM) begin
              rdata_next = bp_conn_mem[host_idx];
            end else if (i_mem_select == tcm_pkg::SEL_LOCAL_DM) begin
              rdata_next = {8'h00, local_dm[page_reg][host_idx]};
            end else if (i_mem_select == tcm_pkg::SEL_BP_DM) begin
              rdata_next = {8'h00, bp_dm[page_reg][host_idx]};
            end
          end
        end
      end
      tcm_pkg::HS_ACK: begin
        // ack held until the host drops select or strobe
        if (!host_sel) begin
          hs_next = tcm_pkg::HS_IDLE;
          ack_n_next = 1'b1;
          oe_next = 1'b0;
        end
      end
      default: hs_next = tcm_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hs_reg <= tcm_pkg::HS_IDLE;
      rdata_reg <= 16'h0000;
      oe_reg <= 1'b0;
      inv_reg <= 1'b0;
      ack_n_reg <= 1'b1;
    end else begin
      hs_reg <= hs_next;
      rdata_reg <= rdata_next;
      oe_reg <= oe_next;
      inv_reg <= inv_next;
      ack_n_reg <= ack_n_next;
    end
  end

  // memory writes; block fill has priority over the host
  always_ff @(posedge i_clock) begin
    if (bp_write) begin
      local_conn_mem[bp_idx_reg] <= {lbd_reg, 13'h0000};
      bp_conn_mem[bp_idx_reg] <= {bbd_reg, 13'h0000};
    end else if (host_cm_wr) begin
      if (i_mem_select == tcm_pkg::SEL_LOCAL_CM) begin
        local_conn_mem[host_idx] <= pins_sync.wdata;
      end
      if (i_mem_select == tcm_pkg::SEL_BP_CM) begin
        bp_conn_mem[host_idx] <= pins_sync.wdata;
      end
    end
    if (i_dm_wr.valid) begin
      if (i_dm_wr.bp_port) begin
        bp_dm[page_reg][{i_dm_wr.stream, i_dm_wr.channel}] <= i_dm_wr.data;
      end else begin
        local_dm[page_reg][{i_dm_wr.stream, i_dm_wr.channel}] <= i_dm_wr.data;
      end
    end
  end

  // outputs
  assign o_data = rdata_reg;
  assign o_data_oe = oe_reg;
  assign o_read_invalid = inv_reg;
  assign o_transfer_ack_n = ack_n_reg;
  assign o_block_prog_enable_bit = bpe_reg;
  assign o_bp_tristate_ctrl_out = ctrl_reg;
  assign o_bp_tristate_ctrl_oe = ctrl_oe_reg;
  assign o_bp_serial_oe = soe_reg;
  assign o_sw_data = sw_data_reg;
  assign o_sw_valid = sw_valid_reg;
  assign o_frame_page = page_reg;
endmodule : tcm_ctrl

// ===== hdl/tcm_pkg.sv
// shared constants and types for the connection-memory controller
package tcm_pkg;
  localparam int CM_WIDTH = 16;
  localparam int CM_DEPTH = 4096;
  localparam int IDX_W = 12;
  localparam int NUM_STREAMS = 16;
  localparam int PERIODS_PER_FRAME = 2048;
  localparam int PAGES = 4;
  localparam logic [10:0] CTRL_START_PERIOD = 11'h7f7;
  localparam logic [10:0] LAST_COUNT = 11'h7ff;
  localparam int BIT_DIV = 6;
  localparam int BP_LIMIT_US = 125;
  localparam int CLK_MHZ = 100;
  localparam int BP_LIMIT_CYCLES = BP_LIMIT_US * CLK_MHZ;
  localparam int SRC_PORT_BIT = 15;
  localparam int MSG_MODE_BIT = 14;
  localparam int OUT_EN_BIT = 13;
  localparam int MEM_SPACE_BIT = 14;
  localparam logic [2:0] SEL_LOCAL_CM = 3'h0;
  localparam logic [2:0] SEL_BP_CM = 3'h1;
  localparam logic [2:0] SEL_LOCAL_DM = 3'h2;
  localparam logic [2:0] SEL_BP_DM = 3'h3;
  localparam logic [2:0] BLOCK_DATA_RESET = 3'h0;
  localparam logic [15:0] INVALID_DATA = 16'hffff;

  typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M} tcm_rate_e;
  typedef enum logic [0:0] {HS_IDLE, HS_ACK} tcm_host_state_e;

  typedef struct packed {
    logic cs_n;
    logic ds_n;
    logic rw;
    logic [14:0] addr;
    logic [15:0] wdata;
  } tcm_host_pins_s;

  typedef struct packed {
    logic valid;
    logic bp_port;
    logic [3:0] stream;
    logic [7:0] channel;
    logic [7:0] data;
  } tcm_dm_wr_s;

  typedef struct packed {
    logic valid;
    logic bp_port;
    logic [3:0] stream;
    logic [7:0] channel;
  } tcm_sw_req_s;
endpackage : tcm_pkg

// ===== hdl/tcm_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module tcm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule : tcm_sync

// ===== tb/tcm_ctrl_sva.sv
// port-level assertions for the connection-memory controller
`timescale 1ns/10ps
module tcm_ctrl_sva #(
  parameter int DEPTH = 4096
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // host port
  input wire logic i_cs_n,
  input wire logic i_ds_n,
  input wire logic i_rw,
  input wire logic [15:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_read_invalid,
  input wire logic o_transfer_ack_n,
  // block programming
  input wire logic i_block_prog_mode_bit,
  input wire logic i_block_prog_enable_set,
  input wire logic i_block_prog_enable_clear,
  input wire logic o_block_prog_enable_bit,
  // backplane control and pages
  input wire logic i_bp_out_reset_state_pin,
  input wire logic [1:0] o_bp_tristate_ctrl_oe,
  input wire logic [1:0] o_frame_page
);
  // cycles the fill has run so far
  int hi_reg;
  int hi_next;
  always_comb hi_next = o_block_prog_enable_bit ? hi_reg + 1 : 0;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) hi_reg <= 0;
    else hi_reg <= hi_next;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_ack_answer; (!i_cs_n && !i_ds_n) [*3] |=> !o_transfer_ack_n; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack late");
  property p_ack_release; $rose(i_ds_n) && !o_transfer_ack_n |=> !o_transfer_ack_n ##[1:3] o_transfer_ack_n; endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack release wrong");
  property p_invalid; !o_transfer_ack_n && o_read_invalid && i_rw |-> o_data == tcm_pkg::INVALID_DATA; endproperty
  a_invalid: assert property (p_invalid) else $error("invalid read data wrong");
  property p_data_oe; $fell(o_transfer_ack_n) |-> o_data_oe == i_rw; endproperty
  a_data_oe: assert property (p_data_oe) else $error("data enable wrong");
  property p_bpe_start; $rose(o_block_prog_enable_bit) |-> $past(i_block_prog_enable_set) && $past(i_block_prog_mode_bit); endproperty
  a_bpe_start: assert property (p_bpe_start) else $error("fill started without request");
  property p_bpe_abort; o_block_prog_enable_bit && (i_block_prog_enable_clear || !i_block_prog_mode_bit) |=> !o_block_prog_enable_bit; endproperty
  a_bpe_abort: assert property (p_bpe_abort) else $error("fill not stopped");
  property p_bpe_len; $fell(o_block_prog_enable_bit) && $past(i_block_prog_mode_bit) && !$past(i_block_prog_enable_clear) |-> hi_reg == DEPTH; endproperty
  a_bpe_len: assert property (p_bpe_len) else $error("fill length wrong");
  property p_bpe_limit; hi_reg <= tcm_pkg::BP_LIMIT_CYCLES; endproperty
  a_bpe_limit: assert property (p_bpe_limit) else $error("fill too long");
  property p_ctrl_hiz; i_bp_out_reset_state_pin [*8] |-> o_bp_tristate_ctrl_oe == 2'h0; endproperty
  a_ctrl_hiz: assert property (p_ctrl_hiz) else $error("control lines driven");
  property p_page; o_frame_page != $past(o_frame_page) |-> o_frame_page == $past(o_frame_page) + 2'h1; endproperty
  a_page: assert property (p_page) else $error("page order wrong");
endmodule : tcm_ctrl_sva
bind tcm_ctrl tcm_ctrl_sva #(.DEPTH(DEPTH)) tcm_ctrl_sva_i (.i_clock, .i_rst, .i_cs_n, .i_ds_n, .i_rw, .o_data, .o_data_oe,
  .o_read_invalid, .o_transfer_ack_n, .i_block_prog_mode_bit, .i_block_prog_enable_set, .i_block_prog_enable_clear,
  .o_block_prog_enable_bit, .i_bp_out_reset_state_pin, .o_bp_tristate_ctrl_oe, .o_frame_page);

// ===== tb/tcm_host.sv
// host bus master model for the controller's port
`timescale 1ns/10ps
module tcm_host (
  // clock
  input wire logic i_clock,
  // answer
  input wire logic i_transfer_ack_n,
  input wire logic [15:0] i_data,
  input wire logic i_read_invalid,
  // request pins
  output tcm_pkg::tcm_host_pins_s o_pins
);
  initial o_pins = '{cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, addr: 15'h0, wdata: 16'h0};
  task automatic access(input logic rd, input logic [14:0] a, input logic [15:0] w,
                        output logic [15:0] r, output logic inv, output logic ok);
    int n;
    n = 0;
    @(negedge i_clock);
    o_pins = '{cs_n: 1'b0, ds_n: 1'b0, rw: rd, addr: a, wdata: w};
    do begin
      @(negedge i_clock);
      n++;
    end while (i_transfer_ack_n !== 1'b0 && n < 40);
    ok = (i_transfer_ack_n === 1'b0);
    r = i_data;
    inv = i_read_invalid;
    // released address and data lines show inverse values, never stale ones
    o_pins = '{cs_n: 1'b1, ds_n: 1'b1, rw: rd, addr: ~a, wdata: ~w};
    while (i_transfer_ack_n !== 1'b1 && n < 80) begin
      @(negedge i_clock);
      n++;
    end
    repeat (3) @(negedge i_clock);
  endtask : access
endmodule : tcm_host

// ===== tb/test_tcm_ctrl.sv
// self-checking bench for the connection-memory controller
`timescale 1ns/10ps
module test_tcm_ctrl;
  localparam int DIV = 2;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_master_clock_ok = 1'b1;
  logic [2:0] i_mem_select = 3'h0;
  logic i_block_prog_mode_bit = 1'b0;
  logic i_block_prog_enable_set = 1'b0;
  logic i_block_prog_enable_clear = 1'b0;
  logic [2:0] i_local_block_data = 3'h0;
  logic [2:0] i_bp_block_data = 3'h0;
  logic i_bp_out_reset_state_pin = 1'b0;
  logic [31:0] i_bp_stream_rate = 32'hffffffff;
  tcm_pkg::tcm_dm_wr_s i_dm_wr = '0;
  tcm_pkg::tcm_sw_req_s i_sw_req = '0;
  tcm_pkg::tcm_host_pins_s hp;
  logic [15:0] o_data, o_bp_serial_oe, rdata;
  logic o_data_oe, o_read_invalid, o_transfer_ack_n, o_block_prog_enable_bit, o_sw_valid, inv, ok;
  logic [1:0] o_bp_tristate_ctrl_out, o_bp_tristate_ctrl_oe, o_frame_page;
  logic [7:0] o_sw_data;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int fl, z0, z1, zs;
  tcm_ctrl #(.DIV(DIV)) tcm_ctrl_i (.i_clock, .i_rst, .i_cs_n(hp.cs_n), .i_ds_n(hp.ds_n), .i_rw(hp.rw),
    .i_addr(hp.addr), .i_data(hp.wdata), .o_data, .o_data_oe, .o_read_invalid, .o_transfer_ack_n,
    .i_master_clock_ok, .i_mem_select, .i_block_prog_mode_bit, .i_block_prog_enable_set,
    .i_block_prog_enable_clear, .i_local_block_data, .i_bp_block_data, .o_block_prog_enable_bit,
    .i_bp_out_reset_state_pin, .i_bp_stream_rate, .o_bp_tristate_ctrl_out, .o_bp_tristate_ctrl_oe,
    .o_bp_serial_oe, .i_dm_wr, .i_sw_req, .o_sw_data, .o_sw_valid, .o_frame_page);
  tcm_host tcm_host_i (.i_clock, .i_transfer_ack_n(o_transfer_ack_n), .i_data(o_data),
    .i_read_invalid(o_read_invalid), .o_pins(hp));
  always #5 i_clock = ~i_clock;
  // whole run needs about 55k cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors = errors + 1;
      complete_run();
    end
  end
  task automatic complete_run();
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // memory space: a14 high, index in the low twelve bits
  task automatic mem(input logic [2:0] s, input logic rd, input logic [11:0] ix, input logic [15:0] w);
    @(negedge i_clock);
    i_mem_select = s;
    tcm_host_i.access(rd, {3'h4, ix}, w, rdata, inv, ok);
    chk("ack", 16'h1, {15'h0, ok});
  endtask : mem
  task automatic pulse(input logic clr);
    @(negedge i_clock);
    if (clr) i_block_prog_enable_clear = 1'b1;
    else i_block_prog_enable_set = 1'b1;
    @(negedge i_clock);
    i_block_prog_enable_set = 1'b0;
    i_block_prog_enable_clear = 1'b0;
  endtask : pulse
  task automatic fill(input logic [2:0] lb, input logic [2:0] bb);
    int n;
    n = 0;
    i_local_block_data = lb;
    i_bp_block_data = bb;
    @(negedge i_clock);
    i_block_prog_mode_bit = 1'b1;
    pulse(1'b0);
    chk("bpe on", 16'h1, {15'h0, o_block_prog_enable_bit});
    while (o_block_prog_enable_bit !== 1'b0 && n < tcm_pkg::BP_LIMIT_CYCLES) begin
      @(negedge i_clock);
      n++;
    end
    chk("bpe done", 16'h0, {15'h0, o_block_prog_enable_bit});
  endtask : fill
  // one frame, counting low cycles on the control lines
  task automatic frame();
    logic [1:0] p;
    p = o_frame_page;
    fl = 0;
    z0 = 0;
    z1 = 0;
    zs = 0;
    while (o_frame_page === p && fl < 9000) begin
      @(negedge i_clock);
      fl++;
      z0 += int'(o_bp_tristate_ctrl_out[0] === 1'b0);
      z1 += int'(o_bp_tristate_ctrl_out[1] === 1'b0);
      zs += int'(o_bp_serial_oe[0] === 1'b0);
    end
  endtask : frame
  task automatic sw(input logic bp, input logic [11:0] ix, input logic [7:0] e);
    @(negedge i_clock);
    i_sw_req = '{valid: 1'b1, bp_port: bp, stream: ix[11:8], channel: ix[7:0]};
    @(negedge i_clock);
    i_sw_req.valid = 1'b0;
    chk("sw valid", 16'h1, {15'h0, o_sw_valid});
    chk("sw data", {8'h0, e}, {8'h0, o_sw_data});
  endtask : sw
  task automatic dmw(input logic bp, input logic [7:0] d);
    @(negedge i_clock);
    i_dm_wr = '{valid: 1'b1, bp_port: bp, stream: 4'h0, channel: 8'h00, data: d};
    @(negedge i_clock);
    i_dm_wr.valid = 1'b0;
  endtask : dmw
  task automatic t_fill();
    fill(3'h5, 3'h6);
    for (int i = 0; i < 4; i++) begin
      mem(3'(i / 2), 1'b1, i[0] ? 12'hfff : 12'h000, 16'h0);
      chk("cm fill", i < 2 ? 16'ha000 : 16'hc000, rdata);
    end
  endtask : t_fill
  task automatic t_abort();
    i_local_block_data = 3'h2;
    pulse(1'b0);
    repeat (8) @(negedge i_clock);
    pulse(1'b1);
    chk("abort clr", 16'h0, {15'h0, o_block_prog_enable_bit});
    mem(3'h0, 1'b1, 12'h000, 16'h0);
    chk("abort head", 16'h4000, rdata);
    mem(3'h0, 1'b1, 12'hfff, 16'h0);
    chk("abort tail", 16'ha000, rdata);
    pulse(1'b0);
    repeat (4) @(negedge i_clock);
    i_block_prog_mode_bit = 1'b0;
    @(negedge i_clock);
    chk("abort mode", 16'h0, {15'h0, o_block_prog_enable_bit});
    pulse(1'b0);
    chk("set no mode", 16'h0, {15'h0, o_block_prog_enable_bit});
  endtask : t_abort
  task automatic t_host();
    mem(3'h0, 1'b0, 12'h123, 16'h1234);
    mem(3'h1, 1'b0, 12'h123, 16'h4321);
    mem(3'h0, 1'b1, 12'h123, 16'h0);
    chk("lcm rw", 16'h1234, rdata);
    mem(3'h1, 1'b1, 12'h123, 16'h0);
    chk("bcm rw", 16'h4321, rdata);
    mem(3'h0, 1'b1, 12'h124, 16'h0);
    chk("lcm next", 16'ha000, rdata);
    tcm_host_i.access(1'b1, 15'h0123, 16'h0, rdata, inv, ok);
    chk("reg space", 16'h0, rdata);
    i_master_clock_ok = 1'b0;
    repeat (4) @(negedge i_clock);
    mem(3'h0, 1'b1, 12'h123, 16'h0);
    chk("no clock flag", 16'h1, {15'h0, inv});
    chk("no clock data", tcm_pkg::INVALID_DATA, rdata);
    i_master_clock_ok = 1'b1;
    repeat (4) @(negedge i_clock);
  endtask : t_host
  task automatic t_delay();
    fill(3'h0, 3'h1);
    // source fields kept in range by the host
    mem(3'h0, 1'b0, 12'h005, 16'h5f3c);
    sw(1'b0, 12'h005, 8'h3c);
    frame();
    dmw(1'b1, 8'h5a);
    dmw(1'b0, 8'ha5);
    mem(3'h3, 1'b1, 12'h000, 16'h0);
    chk("bp dm read", 16'h005a, rdata);
    mem(3'h2, 1'b0, 12'h000, 16'h0077);
    mem(3'h2, 1'b1, 12'h000, 16'h0);
    chk("dm read only", 16'h00a5, rdata);
    frame();
    dmw(1'b1, 8'h11);
    dmw(1'b0, 8'hee);
    frame();
    frame();
    sw(1'b0, 12'h307, 8'h5a);
    sw(1'b1, 12'h307, 8'ha5);
    mem(3'h0, 1'b0, 12'h306, 16'h8000);
    sw(1'b0, 12'h306, 8'ha5);
    frame();
    sw(1'b0, 12'h307, 8'h11);
    sw(1'b1, 12'h307, 8'hee);
  endtask : t_delay
  task automatic t_ctrl();
    mem(3'h1, 1'b0, 12'h000, 16'h0000);
    frame();
    frame();
    chk("frame len", 16'(2048 * DIV), 16'(fl));
    chk("line0 16M", 16'(DIV), 16'(z0));
    chk("line1", 16'h0, 16'(z1));
    chk("serial oe", 16'h0, 16'(zs));
    chk("ctrl oe", 16'h3, {14'h0, o_bp_tristate_ctrl_oe});
    i_bp_stream_rate = 32'hfffffffc;
    frame();
    frame();
    chk("line0 2M", 16'(8 * DIV), 16'(z0));
    i_bp_out_reset_state_pin = 1'b1;
    frame();
    frame();
    chk("hiz channel", 16'(64 * DIV), 16'(zs));
    chk("ctrl hiz", 16'h0, {14'h0, o_bp_tristate_ctrl_oe});
  endtask : t_ctrl
  initial begin
    repeat (20) @(negedge i_clock);
    chk("ack reset", 16'h1, {15'h0, o_transfer_ack_n});
    chk("bpe reset", 16'h0, {15'h0, o_block_prog_enable_bit});
    i_rst = 1'b0;
    t_fill();
    t_abort();
    t_host();
    t_delay();
    t_ctrl();
    complete_run();
  end
endmodule : test_tcm_ctrl
